// *** hw/rdc_pkg.sv ***
// Constants and types for the counter debug, clock source and count register slice
package rdc_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [3:0] RDC_IDX_STATUS = 4'h1;
  localparam logic [3:0] RDC_IDX_TEMP   = 4'h4;
  localparam logic [3:0] RDC_IDX_DBG    = 4'h5;
  localparam logic [3:0] RDC_IDX_SRC    = 4'h7;
  localparam logic [3:0] RDC_IDX_VAL_LO = 4'h8;
  localparam logic [3:0] RDC_IDX_VAL_HI = 4'h9;
  localparam int         RDC_ADDR_W     = 12;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RDC_BIT_RUN  = 0;
  localparam int RDC_BIT_BUSY = 1;

  // ----------------------------------------------------------------
  // Reset values and counts
  // ----------------------------------------------------------------
  localparam logic [7:0]  RDC_RST_DBG    = 8'h00;
  localparam logic [7:0]  RDC_RST_SRC    = 8'h00;
  localparam logic [15:0] RDC_RST_VAL    = 16'h0000;
  localparam logic [7:0]  RDC_RST_TEMP   = 8'h00;
  localparam logic [1:0]  RDC_SYNC_TICKS = 2'h2;
  localparam int          RDC_NUM_SRC    = 3;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    RDC_SRC_FAST = 2'h0,
    RDC_SRC_SLOW = 2'h1,
    RDC_SRC_RSVD = 2'h2,
    RDC_SRC_EXT  = 2'h3
  } rdc_src_e;

  typedef struct packed {
    logic     run_while_halted;
    rdc_src_e clock_source_field;
  } rdc_ctrl_s;

endpackage : rdc_pkg

// *** hw/rdc_top.sv ***
// Counter debug halt, clock source select and synchronised 16-bit count register
//
// Implementation choice: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// How it works
// (R1) Halted without run bit: counter frozen, ticks ignored
// (R2) Run bit set: counter keeps counting while halted
// (R3) Source field picks fast, slow or external clock
// (R4) Count is two bytes, low then high
// (R5) Written count lands after two counter ticks
// (R6) Software waits for busy clear before writing
// (R7) Busy flag high while written count transfers
// (R8) One shared staging byte serves 16-bit access
// (R9) Reserved source code write keeps previous source
module rdc_top
  import rdc_pkg::*;
(
  // APB clock and reset
  input  wire logic                  pclk,
  input  wire logic                  presetn,
  // APB slave
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [RDC_ADDR_W-1:0] paddr,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  // Processor debug state, same clock
  input  wire logic                  debug_halt,
  // Counter clock source pins
  input  wire logic                  ultra_low_power_oscillator,
  input  wire logic                  osc_div_1k,
  input  wire logic                  ext_clock_pin,
  // Counter state
  output logic      [15:0]           count_value,
  output logic                       count_sync_pending
);

  // ----------------------------------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------------------------------
  logic [RDC_NUM_SRC-1:0] src_raw;
  logic [RDC_NUM_SRC-1:0] src_m_q;
  logic [RDC_NUM_SRC-1:0] src_s_q;
  logic [RDC_NUM_SRC-1:0] src_p_q;
  logic [RDC_NUM_SRC-1:0] src_edge;

  assign src_raw = {ext_clock_pin, osc_div_1k, ultra_low_power_oscillator};

  // Two flops per pin, then a history flop for the rising-edge detect
  for (genvar g = 0; g < RDC_NUM_SRC; g++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        src_m_q[g] <= 1'b0;
        src_s_q[g] <= 1'b0;
        src_p_q[g] <= 1'b0;
      end else begin
        src_m_q[g] <= src_raw[g];
        src_s_q[g] <= src_m_q[g];
        src_p_q[g] <= src_s_q[g];
      end
    end
    assign src_edge[g] = src_s_q[g] & ~src_p_q[g];
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  rdc_ctrl_s   ctrl_q;
  rdc_ctrl_s   ctrl_d;
  logic [7:0]  temp_q;
  logic [7:0]  temp_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic        pready_q;
  logic        pready_d;
  logic        pslverr_q;
  logic        pslverr_d;
  logic [3:0]  idx;
  logic        acc_start;
  logic        acc_done;
  logic        hit;
  logic        load_req;

  // Counter state
  logic [15:0] count_q;
  logic [15:0] count_d;
  logic [15:0] stage_q;
  logic [15:0] stage_d;
  logic        pending_q;
  logic        pending_d;
  logic [1:0]  sync_cnt_q;
  logic [1:0]  sync_cnt_d;
  logic        tick;
  logic        run_tick;

  assign idx       = paddr[5:2];
  assign acc_start = psel & penable & ~pready_q;
  assign acc_done  = psel & penable & pready_q;

  // Address decode, anything outside the map answers with an error
  always_comb begin
    hit = 1'b0;
    if (paddr[RDC_ADDR_W-1:6] != '0 || paddr[1:0] != 2'h0) begin
      hit = 1'b0;
    end else if (idx == RDC_IDX_STATUS || idx == RDC_IDX_TEMP || idx == RDC_IDX_DBG) begin
      hit = 1'b1;
    end else if (idx == RDC_IDX_SRC || idx == RDC_IDX_VAL_LO || idx == RDC_IDX_VAL_HI) begin
      hit = 1'b1;
    end
  end

  // High-byte write completes the 16-bit count write
  assign load_req = acc_done & pwrite & hit & (idx == RDC_IDX_VAL_HI);

  // ----------------------------------------------------------------
  // APB slave: one wait state, writes land at the completing edge
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_d    = ctrl_q;
    temp_d    = temp_q;
    prdata_d  = prdata_q;
    pready_d  = acc_start;
    pslverr_d = acc_start & ~hit;
    // Read data and the read side effect are taken together so the pair stays atomic
    if (acc_start && !pwrite && hit) begin
      prdata_d = 32'h0000_0000;
      if (idx == RDC_IDX_STATUS) begin
        prdata_d[RDC_BIT_BUSY] = pending_q; // R7
      end else if (idx == RDC_IDX_TEMP) begin
        prdata_d[7:0] = temp_q;
      end else if (idx == RDC_IDX_DBG) begin
        prdata_d[RDC_BIT_RUN] = ctrl_q.run_while_halted;
      end else if (idx == RDC_IDX_SRC) begin
        prdata_d[1:0] = ctrl_q.clock_source_field;
      end else if (idx == RDC_IDX_VAL_LO) begin
        prdata_d[7:0] = count_q[7:0]; // R4
        temp_d        = count_q[15:8]; // R8
      end else if (idx == RDC_IDX_VAL_HI) begin
        prdata_d[7:0] = temp_q; // R8
      end
    end else if (acc_start) begin
      prdata_d = 32'h0000_0000;
    end
    if (acc_done && pwrite && hit) begin
      if (idx == RDC_IDX_TEMP || idx == RDC_IDX_VAL_LO) begin
        temp_d = pwdata[7:0]; // R8
      end else if (idx == RDC_IDX_DBG) begin
        ctrl_d.run_while_halted = pwdata[RDC_BIT_RUN];
      end else if (idx == RDC_IDX_SRC) begin
        if (rdc_src_e'(pwdata[1:0]) != RDC_SRC_RSVD) begin
          ctrl_d.clock_source_field = rdc_src_e'(pwdata[1:0]); // R9
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q.run_while_halted   <= RDC_RST_DBG[RDC_BIT_RUN];
      ctrl_q.clock_source_field <= rdc_src_e'(RDC_RST_SRC[1:0]);
      temp_q                    <= RDC_RST_TEMP;
      prdata_q                  <= 32'h0000_0000;
      pready_q                  <= 1'b0;
      pslverr_q                 <= 1'b0;
    end else begin
      ctrl_q    <= ctrl_d;
      temp_q    <= temp_d;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // ----------------------------------------------------------------
  // Counter: source select, debug gating, synchronised load
  // ----------------------------------------------------------------
  always_comb begin
    case (ctrl_q.clock_source_field)
      RDC_SRC_FAST: tick = src_edge[0]; // R3
      RDC_SRC_SLOW: tick = src_edge[1]; // R3
      RDC_SRC_EXT:  tick = src_edge[2]; // R3
      default:      tick = src_edge[0];
    endcase
  end

  // Halt freezes counting and the load transfer alike
  assign run_tick = tick & ~(debug_halt & ~ctrl_q.run_while_halted); // R1 R2

  always_comb begin
    count_d    = count_q;
    stage_d    = stage_q;
    pending_d  = pending_q;
    sync_cnt_d = sync_cnt_q;
    if (run_tick) begin
      count_d = count_q + 16'h0001; // R2
    end
    // A new write restarts the transfer; software is meant to wait for busy clear
    if (load_req) begin
      stage_d    = {pwdata[7:0], temp_q}; // R4 R6 R8
      pending_d  = 1'b1; // R7
      sync_cnt_d = 2'h0;
    end else if (pending_q && run_tick) begin
      if (sync_cnt_q == RDC_SYNC_TICKS - 2'h1) begin
        count_d    = stage_q; // R5
        pending_d  = 1'b0; // R7
        sync_cnt_d = 2'h0;
      end else begin
        sync_cnt_d = sync_cnt_q + 2'h1; // R5
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_q    <= RDC_RST_VAL;
      stage_q    <= RDC_RST_VAL;
      pending_q  <= 1'b0;
      sync_cnt_q <= 2'h0;
    end else begin
      count_q    <= count_d;
      stage_q    <= stage_d;
      pending_q  <= pending_d;
      sync_cnt_q <= sync_cnt_d;
    end
  end

  // Outputs straight from flops
  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign count_value        = count_q;
  assign count_sync_pending = pending_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  halt_freeze_a: assert property (@(posedge pclk) disable iff (!presetn) // R1
    (debug_halt && !ctrl_q.run_while_halted) |=> $stable(count_q) && $stable(sync_cnt_q))
    else $error("count moved while halted");

  run_count_a: assert property (@(posedge pclk) disable iff (!presetn) // R2
    (tick && ctrl_q.run_while_halted && !pending_q && !load_req) |=> count_q == $past(count_q) + 16'h0001)
    else $error("count did not advance on tick");

  src_keep_a: assert property (@(posedge pclk) disable iff (!presetn) // R9
    (acc_done && pwrite && hit && idx == RDC_IDX_SRC && pwdata[1:0] == 2'h2)
    |=> ctrl_q.clock_source_field == $past(ctrl_q.clock_source_field))
    else $error("reserved source code changed selection");

  src_select_a: assert property (@(posedge pclk) disable iff (!presetn) // R3
    (ctrl_q.clock_source_field == RDC_SRC_EXT) |-> tick == src_edge[2])
    else $error("external source not selected");

  sync_land_a: assert property (@(posedge pclk) disable iff (!presetn) // R5
    (pending_q && run_tick && sync_cnt_q == 2'h1 && !load_req) |=> (count_q == $past(stage_q)) && !pending_q)
    else $error("count not loaded on second tick");

  busy_set_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    load_req |=> pending_q && sync_cnt_q == 2'h0 && stage_q == {$past(pwdata[7:0]), $past(temp_q)})
    else $error("busy or staged value wrong after write");

  busy_read_a: assert property (@(posedge pclk) disable iff (!presetn) // R7
    (acc_start && !pwrite && idx == RDC_IDX_STATUS && paddr[RDC_ADDR_W-1:6] == '0 && paddr[1:0] == 2'h0)
    |=> prdata_q[RDC_BIT_BUSY] == $past(pending_q))
    else $error("status busy bit wrong");

  temp_latch_a: assert property (@(posedge pclk) disable iff (!presetn) // R8
    (acc_start && !pwrite && hit && idx == RDC_IDX_VAL_LO)
    |=> temp_q == $past(count_q[15:8]) && prdata_q[7:0] == $past(count_q[7:0]))
    else $error("low byte read did not latch high byte");

  apb_err_a: assert property (@(posedge pclk) disable iff (!presetn)
    (acc_start && !hit) |=> pready_q && pslverr_q ##1 !pready_q)
    else $error("unmapped access not refused");

endmodule : rdc_top

`default_nettype wire

// *** verification/rdc_top_tb.sv ***
// Self-checking testbench for the counter debug, clock source and count register slice
`timescale 1ns/10ps
`default_nettype none
module rdc_top_tb
  import rdc_pkg::*;
;
  // ----------------------------------------------------------------
  // Stimulus and observation
  // ----------------------------------------------------------------
  logic                  pclk = 1'b0;
  logic                  presetn = 1'b0;
  logic                  psel = 1'b0;
  logic                  penable = 1'b0;
  logic                  pwrite = 1'b0;
  logic [RDC_ADDR_W-1:0] paddr = '0;
  logic [31:0]           pwdata = '0;
  logic [31:0]           prdata;
  logic                  pready;
  logic                  pslverr;
  logic                  debug_halt = 1'b0;
  logic [2:0]            pins = 3'h0;
  logic [15:0]           count_value;
  logic                  count_sync_pending;
  logic [7:0]            rd;
  logic                  er;
  logic [15:0]           c0;
  int                    n_fail = 0;
  int                    samples_checked = 0;

  always #25 pclk = ~pclk;

  rdc_top u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .debug_halt(debug_halt), .ultra_low_power_oscillator(pins[0]), .osc_div_1k(pins[1]),
    .ext_clock_pin(pins[2]), .count_value(count_value), .count_sync_pending(count_sync_pending)
  );

  // ----------------------------------------------------------------
  // Shared helpers
  // ----------------------------------------------------------------
  task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    samples_checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // One APB transfer; request held until pready is seen high at a rising edge
  task apb(input logic w, input logic [3:0] idx, input logic [7:0] d);
    int k;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {6'h00, idx, 2'b00};
    pwdata  <= {24'h000000, d};
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    // Values read here are those in force just before the edge
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    if (k >= 20) chk("pready", 16'h0001, 16'h0000);
    rd      = prdata[7:0];
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task rchk(input string what, input logic [3:0] idx, input logic [7:0] exp);
    apb(1'b0, idx, 8'h00);
    chk(what, {8'h00, exp}, {8'h00, rd});
  endtask : rchk

  // Pulses of 4 cycles, well below half the bus clock rate
  task tick(input int b, input int n);
    repeat (n) begin
      @(posedge pclk) pins[b] <= 1'b1;
      repeat (4) @(posedge pclk);
      pins[b] <= 1'b0;
      repeat (4) @(posedge pclk);
    end
    repeat (4) @(posedge pclk);
  endtask : tick

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task t_reset();
    rchk("status", RDC_IDX_STATUS, 8'h00);
    rchk("temp", RDC_IDX_TEMP, RDC_RST_TEMP);
    rchk("debug", RDC_IDX_DBG, RDC_RST_DBG);
    rchk("source", RDC_IDX_SRC, RDC_RST_SRC);
    rchk("cnt_lo", RDC_IDX_VAL_LO, RDC_RST_VAL[7:0]);
    rchk("cnt_hi", RDC_IDX_VAL_HI, RDC_RST_VAL[15:8]);
    apb(1'b0, 4'h2, 8'h00);
    chk("unmapped_err", 16'h0001, {15'h0000, er});
  endtask : t_reset

  // Every source code, then the reserved one which must not take
  task t_source();
    logic [1:0] code [3] = '{2'h0, 2'h1, 2'h3};
    for (int i = 0; i < 3; i++) begin
      apb(1'b1, RDC_IDX_SRC, {6'h00, code[i]});
      rchk("source_rb", RDC_IDX_SRC, {6'h00, code[i]});
      c0 = count_value;
      tick(i, 3);
      chk("count_sel", c0 + 16'h0003, count_value);
      tick((i + 1) % 3, 2);
      chk("count_unsel", c0 + 16'h0003, count_value);
    end
    apb(1'b1, RDC_IDX_SRC, 8'h02);
    rchk("source_rsvd", RDC_IDX_SRC, 8'h03);
    c0 = count_value;
    tick(2, 2);
    chk("count_rsvd", c0 + 16'h0002, count_value);
  endtask : t_source

  // Write 16-bit count, watch busy and the two-tick landing, then atomic read
  task t_count();
    rchk("status_pre", RDC_IDX_STATUS, 8'h00);
    apb(1'b1, RDC_IDX_VAL_LO, 8'hFF);
    apb(1'b1, RDC_IDX_VAL_HI, 8'h12);
    repeat (2) @(posedge pclk);
    chk("pending", 16'h0001, {15'h0000, count_sync_pending});
    rchk("status_busy", RDC_IDX_STATUS, 8'h02);
    tick(2, 1);
    chk("pending_1tick", 16'h0001, {15'h0000, count_sync_pending});
    tick(2, 1);
    chk("count_loaded", 16'h12FF, count_value);
    rchk("status_idle", RDC_IDX_STATUS, 8'h00);
    rchk("cnt_lo_rd", RDC_IDX_VAL_LO, 8'hFF);
    tick(2, 1);
    chk("count_wrap", 16'h1300, count_value);
    rchk("cnt_hi_rd", RDC_IDX_VAL_HI, 8'h12);
    rchk("temp_rd", RDC_IDX_TEMP, 8'h12);
  endtask : t_count

  // Halt freezes the counter unless the run bit is set
  task t_halt();
    @(posedge pclk) debug_halt <= 1'b1;
    apb(1'b1, RDC_IDX_DBG, 8'h00);
    c0 = count_value;
    tick(2, 3);
    chk("count_halted", c0, count_value);
    apb(1'b1, RDC_IDX_DBG, 8'h01);
    rchk("debug_rb", RDC_IDX_DBG, 8'h01);
    tick(2, 3);
    chk("count_run", c0 + 16'h0003, count_value);
    @(posedge pclk) debug_halt <= 1'b0;
  endtask : t_halt

  // Temp written directly, then a reset in mid-transfer clears busy, count and temp
  task t_rerun();
    apb(1'b1, RDC_IDX_TEMP, 8'h5A);
    rchk("temp_wr", RDC_IDX_TEMP, 8'h5A);
    apb(1'b1, RDC_IDX_VAL_HI, 8'h34);
    @(posedge pclk);
    chk("pending_pre_rst", 16'h0001, {15'h0000, count_sync_pending});
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk("count_rst", RDC_RST_VAL, count_value);
    chk("pending_rst", 16'h0000, {15'h0000, count_sync_pending});
    presetn <= 1'b1;
    rchk("temp_rst", RDC_IDX_TEMP, RDC_RST_TEMP);
    rchk("status_rst", RDC_IDX_STATUS, 8'h00);
  endtask : t_rerun

  // ----------------------------------------------------------------
  // Verdict and main sequence
  // ----------------------------------------------------------------
  task end_of_test();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : end_of_test

  // Watchdog sized well past the few hundred cycles the tests take
  initial begin
    #(50 * 20000);
    n_fail++;
    end_of_test();
  end

  initial begin
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_source();
    t_count();
    t_halt();
    t_rerun();
    end_of_test();
  end
endmodule : rdc_top_tb
`default_nettype wire
